// ==== verilog/sdm_pkg.sv ====
// shared constants and types for the sdram module command interface
package sdm_pkg;

   // ****************************************
   // data path and address widths
   // ****************************************
   localparam int DATA_W = 64;
   localparam int LANES = 8;
   localparam int ADDR_W = 13;
   localparam int COL_W = 10;
   localparam int BANKS = 4;
   localparam int RANKS = 4;
   // storage kept small: bank, low row bits, low column bits
   localparam int MEM_ROW_BITS = 3;
   localparam int MEM_COL_BITS = 5;
   localparam int MEM_IDX_W = 2 + MEM_ROW_BITS + MEM_COL_BITS;
   localparam int MEM_DEPTH = 1 << MEM_IDX_W;

   // ****************************************
   // address and mode field positions
   // ****************************************
   localparam int AP_BIT = 10;
   localparam int MODE_W = 12;
   localparam int M_BL_LSB = 0;
   localparam int M_ORDER = 3;
   localparam int M_CL_LSB = 4;
   localparam int M_OPMODE_LSB = 7;
   localparam int M_WBURST = 9;
   localparam logic [MODE_W-1:0] MODE_RESET = 12'h020;
   localparam logic [2:0] BL_CODE_PAGE = 3'h7;

   // ****************************************
   // wishbone register map
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_REFCNT = 8'h08;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam int ST_STATE_LSB = 12;
   localparam int ST_OPEN_LSB = 20;
   localparam int ST_GROUP = 24;

   // ****************************************
   // commands and states
   // ****************************************
   typedef enum logic [3:0] {
      CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_PRECHARGE,
      CMD_REFRESH, CMD_MODE_SET, CMD_TERMINATE, CMD_MASKED
   } sdm_cmd_t;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_READ = 6'h02,
      ST_WRITE = 6'h04,
      ST_PWRDN = 6'h08,
      ST_SELFREF = 6'h10,
      ST_SUSPEND = 6'h20
   } sdm_state_t;

endpackage

// ==== verilog/sdm_burst_seq.sv ====
// column sequencer for one beat of a wrapped burst
`timescale 1ns/100ps
module sdm_burst_seq
   import sdm_pkg::*;
(
   input wire logic [COL_W-1:0] start_in,
   input wire logic [COL_W-1:0] index_in,
   input wire logic [COL_W-1:0] wrap_mask_in,
   input wire logic interleave_in,
   output logic [COL_W-1:0] col_out
);

   // ****************************************
   // block select from upper bits, offset in block
   // ****************************************
   logic [COL_W-1:0] low_sum;
   logic [COL_W-1:0] low_xor;

   // wraps within the block; full page mask wraps in page
   always_comb begin
      low_sum = COL_W'(start_in + index_in) & wrap_mask_in;
      low_xor = (start_in ^ index_in) & wrap_mask_in;
      col_out = (start_in & ~wrap_mask_in) |
                (interleave_in ? low_xor : low_sum);
   end

endmodule

// ==== verilog/sdm_cmd_if.sv ====
// device side command, address and data pin logic of the dram module
// How it works
// - strobes plus rank select form the command
// - all inputs sampled on rising clock edge
// - each edge advances burst and output registers
// - clock enable high runs, low stops clock
// - enable low: idle powers down, burst suspends
// - in power-down, enable treated as asynchronous; here a level sampled on the rising edge
// - power-down ignores all inputs except enable
// - rank select low enables, high masks command
// - write mask high keeps stored byte
// - read mask high floats lane two cycles later
// - bank bits pick target bank
// - address is row on activate, column otherwise
// - bit ten on access requests auto precharge
// - bit ten on precharge selects all banks
// - mode set takes op-code from address
// - mode fields: length, order, latency, mode, write
// - burst wraps inside length-aligned column block
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
module sdm_cmd_if
   import sdm_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic [RANKS-1:0] RANK_SELECT_N_IN,
   input wire logic ROW_STROBE_N_IN,
   input wire logic COL_STROBE_N_IN,
   input wire logic WRITE_ENABLE_N_IN,
   input wire logic [1:0] CLOCK_ENABLE_LINES_IN,
   input wire logic [1:0] BANK_ADDRESS_BITS_IN,
   input wire logic [ADDR_W-1:0] MULTIPLEXED_ADDRESS_IN,
   input wire logic [LANES-1:0] BYTE_LANE_MASK_IN,
   input wire logic [DATA_W-1:0] DATA_BUS_LINES_IN,
   output logic [DATA_W-1:0] DATA_BUS_LINES_OUT,
   output logic [LANES-1:0] DATA_BUS_LINES_OE_OUT,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [7:0] WB_ADR_IN,
   input wire logic [3:0] WB_SEL_IN,
   input wire logic [31:0] WB_DAT_IN,
   output logic [31:0] WB_DAT_OUT,
   output logic WB_ACK_OUT
);

   // ****************************************
   // helpers
   // ****************************************
   // customary truth table, chip select part of the code
   function automatic sdm_cmd_t decode(input logic sel_n,
      input logic ras_n, input logic cas_n, input logic we_n);
      sdm_cmd_t c;
      c = CMD_NOP;
      if (sel_n) begin
         c = CMD_MASKED;
      end else begin
         case ({ras_n, cas_n, we_n})
            3'h3: c = CMD_ACTIVE;
            3'h5: c = CMD_READ;
            3'h4: c = CMD_WRITE;
            3'h2: c = CMD_PRECHARGE;
            3'h1: c = CMD_REFRESH;
            3'h0: c = CMD_MODE_SET;
            3'h6: c = CMD_TERMINATE;
            default: c = CMD_NOP;
         endcase
      end
      return c;
   endfunction

   // burst length code to wrap mask; reserved codes act as length one
   function automatic logic [COL_W-1:0] wrap_of(input logic [2:0] code);
      logic [COL_W-1:0] m;
      m = 10'h000;
      case (code)
         3'h1: m = 10'h001;
         3'h2: m = 10'h003;
         3'h3: m = 10'h007;
         BL_CODE_PAGE: m = 10'h3FF;
         default: m = 10'h000;
      endcase
      return m;
   endfunction

   // ****************************************
   // state
   // ****************************************
   sdm_state_t state, next_state;
   logic [MODE_W-1:0] mode, next_mode;
   logic [BANKS-1:0] open_bank, next_open_bank;
   logic [MEM_ROW_BITS-1:0] open_row [BANKS];
   logic [MEM_ROW_BITS-1:0] next_open_row [BANKS];
   logic [1:0] b_bank, next_b_bank;
   logic [COL_W-1:0] b_start, next_b_start;
   logic [COL_W-1:0] b_idx, next_b_idx;
   logic [COL_W-1:0] b_wrap, next_b_wrap;
   logic b_ap, next_b_ap;
   logic b_wr, next_b_wr;
   logic grp, next_grp;
   logic [15:0] refcnt, next_refcnt;
   logic [3:0] rank_off, next_rank_off;
   logic [31:0] wb_dat, next_wb_dat;
   logic wb_ack, next_wb_ack;
   // read pipeline: stage one, stage two, output
   logic [DATA_W-1:0] p1, next_p1, p2, next_p2, dout, next_dout;
   logic p1_v, next_p1_v, p2_v, next_p2_v;
   logic [LANES-1:0] mask_q, next_mask_q, oe, next_oe;
   logic [DATA_W-1:0] mem [MEM_DEPTH];

   // ****************************************
   // command sampling
   // ****************************************
   logic sel_n;
   logic cke_cmd;
   logic cke_run;
   sdm_cmd_t cmd;
   logic acc_v, acc_wr;
   logic [1:0] acc_bank;
   logic [COL_W-1:0] acc_start, acc_idx, acc_wrap, acc_col;
   logic acc_order;
   logic [MEM_IDX_W-1:0] acc_addr;
   logic [2:0] lat;

   // ranks 0 and 2 follow enable line 0, ranks 1 and 3 line 1
   always_comb begin
      sel_n = &(RANK_SELECT_N_IN | rank_off);
      cke_cmd = |(~(RANK_SELECT_N_IN | rank_off) &
                  {CLOCK_ENABLE_LINES_IN, CLOCK_ENABLE_LINES_IN});
      cke_run = CLOCK_ENABLE_LINES_IN[grp];
      cmd = decode(sel_n, ROW_STROBE_N_IN, COL_STROBE_N_IN,
                   WRITE_ENABLE_N_IN);
      lat = mode[M_CL_LSB +: 3];
   end

   // ****************************************
   // burst access of this edge
   // ****************************************
   always_comb begin
      acc_v = 1'b0;
      acc_wr = 1'b0;
      acc_bank = b_bank;
      acc_start = b_start;
      acc_idx = b_idx;
      acc_wrap = b_wrap;
      acc_order = mode[M_ORDER];
      // no access while suspended; the frozen burst owns the pins
      if (!(state inside {ST_PWRDN, ST_SELFREF, ST_SUSPEND}) &&
          cke_cmd && (cmd == CMD_READ || cmd == CMD_WRITE)) begin
         acc_v = 1'b1;
         acc_wr = (cmd == CMD_WRITE);
         acc_bank = BANK_ADDRESS_BITS_IN;
         acc_start = MULTIPLEXED_ADDRESS_IN[COL_W-1:0];
         acc_idx = 10'h000;
         acc_wrap = wrap_of(mode[M_BL_LSB +: 3]);
         if (acc_wr && mode[M_WBURST]) begin
            acc_wrap = 10'h000;
         end
      end else if ((state == ST_READ || state == ST_WRITE) && cke_run &&
                   cmd != CMD_TERMINATE && cmd != CMD_PRECHARGE) begin
         acc_v = 1'b1;
         acc_wr = (state == ST_WRITE);
      end
      acc_addr = {acc_bank, open_row[acc_bank],
                  acc_col[MEM_COL_BITS-1:0]};
   end

   sdm_burst_seq u_seq (
      .start_in(acc_start),
      .index_in(acc_idx),
      .wrap_mask_in(acc_wrap),
      .interleave_in(acc_order),
      .col_out(acc_col)
   );

   // ****************************************
   // command and power state machine
   // ****************************************
   always_comb begin
      next_state = state;
      next_mode = mode;
      next_open_bank = open_bank;
      next_open_row = open_row;
      next_b_bank = acc_bank;
      next_b_start = acc_start;
      next_b_wrap = acc_wrap;
      next_b_idx = COL_W'(acc_idx + 10'h001);
      next_b_ap = b_ap;
      next_b_wr = b_wr;
      next_grp = grp;
      next_refcnt = refcnt;
      case (state)
         ST_PWRDN, ST_SELFREF: begin
            // inputs ignored; only the enable is watched, level only
            if (cke_run) begin
               next_state = ST_IDLE;
            end
         end
         ST_SUSPEND: begin
            // burst frozen, counter and pipeline held; the waking edge
            // is spent, so the burst picks up one edge later
            next_b_idx = b_idx;
            if (cke_run) begin
               next_state = b_wr ? ST_WRITE : ST_READ;
            end
         end
         default: begin
            if (cke_cmd) begin
               next_grp = ~RANK_SELECT_N_IN[1] | ~RANK_SELECT_N_IN[3];
            end
            if (!cke_run && cmd != CMD_REFRESH &&
                (state == ST_READ || state == ST_WRITE)) begin
               next_state = ST_SUSPEND;
               next_b_bank = b_bank;
               next_b_idx = b_idx;
               next_b_wr = (state == ST_WRITE);
            end else if (!cke_run && state == ST_IDLE &&
                         cmd != CMD_REFRESH && open_bank == 4'h0) begin
               next_state = ST_PWRDN;
            end else if (cke_cmd || cmd == CMD_MASKED ||
                         cmd == CMD_NOP) begin
               case (cmd)
                  CMD_ACTIVE: begin
                     next_open_bank[BANK_ADDRESS_BITS_IN] = 1'b1;
                     next_open_row[BANK_ADDRESS_BITS_IN] =
                        MULTIPLEXED_ADDRESS_IN[MEM_ROW_BITS-1:0];
                  end
                  CMD_READ, CMD_WRITE: begin
                     next_b_ap = MULTIPLEXED_ADDRESS_IN[AP_BIT];
                  end
                  CMD_PRECHARGE: begin
                     next_state = ST_IDLE;
                     if (MULTIPLEXED_ADDRESS_IN[AP_BIT]) begin
                        next_open_bank = 4'h0;
                     end else begin
                        next_open_bank[BANK_ADDRESS_BITS_IN] = 1'b0;
                     end
                  end
                  CMD_REFRESH: begin
                     next_refcnt = refcnt + 16'h0001;
                  end
                  CMD_MODE_SET: begin
                     // op-code from the address lines
                     next_mode = MULTIPLEXED_ADDRESS_IN[MODE_W-1:0];
                  end
                  CMD_TERMINATE: begin
                     next_state = ST_IDLE;
                  end
                  default: begin
                  end
               endcase
               if (acc_v) begin
                  next_state = acc_wr ? ST_WRITE : ST_READ;
                  if (acc_idx == acc_wrap && acc_wrap != 10'h3FF) begin
                     next_state = ST_IDLE;
                     if (next_b_ap) begin
                        next_open_bank[acc_bank] = 1'b0;
                     end
                  end
               end
            end else if (cmd == CMD_REFRESH && state == ST_IDLE) begin
               // refresh with enable low enters self refresh
               next_state = ST_SELFREF;
               next_refcnt = refcnt + 16'h0001;
            end
         end
      endcase
   end

   // ****************************************
   // read pipe, lane enables, bus slave
   // ****************************************
   always_comb begin
      next_p1 = p1;
      next_p1_v = p1_v;
      next_p2 = p2;
      next_p2_v = p2_v;
      next_dout = dout;
      next_oe = oe;
      next_mask_q = mask_q;
      if (cke_run &&
          !(state inside {ST_PWRDN, ST_SELFREF, ST_SUSPEND})) begin
         next_mask_q = BYTE_LANE_MASK_IN;
         next_p1 = mem[acc_addr];
         next_p1_v = acc_v && !acc_wr;
         next_p2 = p1;
         next_p2_v = p1_v;
         // latency two takes stage one, three takes stage two
         next_dout = (lat == 3'h3) ? p2 : p1;
         next_oe = {LANES{(lat == 3'h3) ? p2_v : p1_v}} &
                   ~mask_q;
      end
      next_rank_off = rank_off;
      next_wb_dat = 32'h00000000;
      next_wb_ack = WB_CYC_IN && WB_STB_IN && !wb_ack;
      if (next_wb_ack && WB_WE_IN && WB_SEL_IN[0] &&
          WB_ADR_IN == REG_CTRL) begin
         next_rank_off = WB_DAT_IN[3:0];
      end
      // unmapped reads answer zero
      case (WB_ADR_IN)
         REG_CTRL: next_wb_dat = {28'h0000000, rank_off};
         REG_STATUS: next_wb_dat = {7'h00, grp, open_bank,
                                    2'h0, state, mode};
         REG_REFCNT: next_wb_dat = {16'h0000, refcnt};
         default: next_wb_dat = 32'h00000000;
      endcase
   end

   // ****************************************
   // storage; masked lanes keep the stored byte
   // ****************************************
   always_ff @(posedge CLK_IN) begin
      if (acc_v && acc_wr) begin
         for (int i = 0; i < LANES; i++) begin
            if (!BYTE_LANE_MASK_IN[i]) begin
               mem[acc_addr][8*i +: 8] <= DATA_BUS_LINES_IN[8*i +: 8];
            end
         end
      end
   end

   // ****************************************
   // registers, all on the rising edge
   // ****************************************
   always_ff @(posedge CLK_IN) begin
      if (!NRST_IN) begin
         state <= ST_IDLE;
         mode <= MODE_RESET;
         open_bank <= 4'h0;
         for (int i = 0; i < BANKS; i++) begin
            open_row[i] <= 3'h0;
         end
         b_bank <= 2'h0;
         b_start <= 10'h000;
         b_idx <= 10'h000;
         b_wrap <= 10'h000;
         b_ap <= 1'b0;
         b_wr <= 1'b0;
         grp <= 1'b0;
         refcnt <= 16'h0000;
         rank_off <= CTRL_RESET;
         wb_dat <= 32'h00000000;
         wb_ack <= 1'b0;
         p1 <= 64'h0000000000000000;
         p2 <= 64'h0000000000000000;
         dout <= 64'h0000000000000000;
         p1_v <= 1'b0;
         p2_v <= 1'b0;
         mask_q <= 8'h00;
         oe <= 8'h00;
      end else begin
         state <= next_state;
         mode <= next_mode;
         open_bank <= next_open_bank;
         open_row <= next_open_row;
         b_bank <= next_b_bank;
         b_start <= next_b_start;
         b_idx <= next_b_idx;
         b_wrap <= next_b_wrap;
         b_ap <= next_b_ap;
         b_wr <= next_b_wr;
         grp <= next_grp;
         refcnt <= next_refcnt;
         rank_off <= next_rank_off;
         wb_dat <= next_wb_dat;
         wb_ack <= next_wb_ack;
         p1 <= next_p1;
         p2 <= next_p2;
         dout <= next_dout;
         p1_v <= next_p1_v;
         p2_v <= next_p2_v;
         mask_q <= next_mask_q;
         oe <= next_oe;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign DATA_BUS_LINES_OUT = dout;
   assign DATA_BUS_LINES_OE_OUT = oe;
   assign WB_DAT_OUT = wb_dat;
   assign WB_ACK_OUT = wb_ack;

endmodule

// ==== testbench/sdm_ctl_model.sv ====
// memory controller model that drives the dram command and data pins
`timescale 1ns/100ps
module sdm_ctl_model
   import sdm_pkg::*;
#(
   parameter int INIT_CYCLES = 12500
)
(
   input wire logic clk_in,
   input wire logic nrst_in,
   output logic [RANKS-1:0] sel_n_out,
   output logic [2:0] rcw_out,
   output logic [1:0] cke_out,
   output logic [1:0] ba_out,
   output logic [ADDR_W-1:0] a_out,
   output logic [LANES-1:0] mask_out,
   output logic [DATA_W-1:0] dq_out,
   output logic ready_out
);
   // strobe codes in row, column, write order, all active low
   localparam logic [2:0] C_NOP = 3'h7;
   localparam logic [2:0] C_ACT = 3'h3;
   localparam logic [2:0] C_RD = 3'h5;
   localparam logic [2:0] C_WR = 3'h4;
   localparam logic [2:0] C_PRE = 3'h2;
   localparam logic [2:0] C_REF = 3'h1;
   localparam logic [2:0] C_MRS = 3'h0;

   // one command, two data and mask beats, then the bus is let go
   task automatic op(input logic [3:0] s, input logic [1:0] k,
      input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
      input logic [63:0] d0, input logic [63:0] d1,
      input logic [7:0] m0, input logic [7:0] m1);
      @(posedge clk_in);
      sel_n_out <= s;
      cke_out <= k;
      rcw_out <= c;
      ba_out <= b;
      a_out <= a;
      dq_out <= d0;
      mask_out <= m0;
      @(posedge clk_in);
      rcw_out <= C_NOP;
      dq_out <= d1;
      mask_out <= m1;
      @(posedge clk_in);
      dq_out <= ~d1; // released bus never shows a stale value
      mask_out <= 8'h00;
   endtask

   // power-up: idle wait, precharge all, two refreshes, then mode
   initial begin
      sel_n_out = 4'h0;
      rcw_out = C_NOP;
      cke_out = 2'h3;
      ba_out = 2'h0;
      a_out = 13'h0000;
      mask_out = 8'h00;
      dq_out = 64'h0;
      ready_out = 1'b0;
      wait (nrst_in === 1'b1);
      repeat (INIT_CYCLES) @(posedge clk_in);
      op(4'h0, 2'h3, C_PRE, 2'h0, 13'h0400, 0, 0, 0, 0);
      op(4'h0, 2'h3, C_REF, 2'h0, 13'h0000, 0, 0, 0, 0);
      op(4'h0, 2'h3, C_REF, 2'h0, 13'h0000, 0, 0, 0, 0);
      // burst of two, sequential, latency two; banks idle here
      op(4'h0, 2'h3, C_MRS, 2'h0, 13'h0021, 0, 0, 0, 0);
      ready_out <= 1'b1;
   end
endmodule

// ==== testbench/sdm_cmd_if_assertions.sv ====
// concurrent checks on the pins and bus of the command interface
`timescale 1ns/100ps
module sdm_cmd_if_assertions
   import sdm_pkg::*;
(
   input wire logic CLK_IN,
   input wire logic NRST_IN,
   input wire logic [RANKS-1:0] RANK_SELECT_N_IN,
   input wire logic ROW_STROBE_N_IN,
   input wire logic COL_STROBE_N_IN,
   input wire logic WRITE_ENABLE_N_IN,
   input wire logic [1:0] CLOCK_ENABLE_LINES_IN,
   input wire logic [LANES-1:0] BYTE_LANE_MASK_IN,
   input wire logic [DATA_W-1:0] DATA_BUS_LINES_OUT,
   input wire logic [LANES-1:0] DATA_BUS_LINES_OE_OUT,
   input wire logic WB_CYC_IN,
   input wire logic WB_STB_IN,
   input wire logic WB_WE_IN,
   input wire logic [7:0] WB_ADR_IN,
   input wire logic [31:0] WB_DAT_OUT,
   input wire logic WB_ACK_OUT
);
   // ****
   // read decode, loose on rank: only a bound on drive
   // ****
   logic rd_cmd;
   assign rd_cmd = (RANK_SELECT_N_IN != 4'hF) && ROW_STROBE_N_IN &&
      !COL_STROBE_N_IN && WRITE_ENABLE_N_IN;

   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!NRST_IN);

   chk_ack_follows: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT
      |=> WB_ACK_OUT) else $error("bus request not answered next cycle");
   chk_ack_single: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("bus ack longer than one cycle");
   chk_ack_needs_req: assert property (!(WB_CYC_IN && WB_STB_IN)
      |=> !WB_ACK_OUT) else $error("bus ack without request");
   chk_unmapped_zero: assert property (WB_ACK_OUT && !WB_WE_IN &&
      WB_ADR_IN > REG_REFCNT |-> WB_DAT_OUT == 32'h0)
      else $error("unmapped read not zero");
   chk_ctrl_upper: assert property (WB_ACK_OUT && !WB_WE_IN &&
      WB_ADR_IN == REG_CTRL |-> WB_DAT_OUT[31:4] == 28'h0)
      else $error("control upper bits not zero");
   chk_mask_floats: assert property (
      (CLOCK_ENABLE_LINES_IN == 2'h3)[*3] |->
      (DATA_BUS_LINES_OE_OUT & $past(BYTE_LANE_MASK_IN, 2)) == 8'h00)
      else $error("masked lane driven two cycles later");
   chk_oe_needs_read: assert property (
      $rose(|DATA_BUS_LINES_OE_OUT) |-> $past(rd_cmd, 2) ||
      $past(rd_cmd, 3) || $past(rd_cmd, 4))
      else $error("data drive without read command");
   chk_frozen_low: assert property (
      (CLOCK_ENABLE_LINES_IN == 2'h0)[*2] |->
      $stable(DATA_BUS_LINES_OE_OUT) && $stable(DATA_BUS_LINES_OUT))
      else $error("outputs moved with clock enable low");

   cover property (rd_cmd ##2 (|DATA_BUS_LINES_OE_OUT));
   cover property (WB_ACK_OUT && !WB_WE_IN);
   cover property ((CLOCK_ENABLE_LINES_IN == 2'h0)[*2]);
   cover property (|BYTE_LANE_MASK_IN && |DATA_BUS_LINES_OE_OUT);
endmodule

bind sdm_cmd_if sdm_cmd_if_assertions chk_u (.CLK_IN(CLK_IN),
   .NRST_IN(NRST_IN), .RANK_SELECT_N_IN(RANK_SELECT_N_IN),
   .ROW_STROBE_N_IN(ROW_STROBE_N_IN), .COL_STROBE_N_IN(COL_STROBE_N_IN),
   .WRITE_ENABLE_N_IN(WRITE_ENABLE_N_IN),
   .CLOCK_ENABLE_LINES_IN(CLOCK_ENABLE_LINES_IN),
   .BYTE_LANE_MASK_IN(BYTE_LANE_MASK_IN),
   .DATA_BUS_LINES_OUT(DATA_BUS_LINES_OUT),
   .DATA_BUS_LINES_OE_OUT(DATA_BUS_LINES_OE_OUT), .WB_CYC_IN(WB_CYC_IN),
   .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
   .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT));

// ==== testbench/sdm_cmd_if_tb.sv ====
// self-checking bench for the dram module command interface
`timescale 1ns/100ps
module sdm_cmd_if_tb
   import sdm_pkg::*;
;
   logic clk, nrst, cyc, stb, we, ack, ready;
   logic [7:0] adr, mask, doe;
   logic [3:0] sel, sel_n;
   logic [31:0] wdat, rdat, r;
   logic [2:0] rcw;
   logic [1:0] cke, ba;
   logic [12:0] a;
   logic [63:0] dqc, dout, dq_wire;
   int mismatches, checks_done;
   localparam logic [63:0] D0 = 64'h0123456789ABCDEF;
   localparam logic [63:0] D1 = 64'hFEDCBA9876543210;
   localparam logic [63:0] E0 = 64'hA5A5A5A5A5A5A5A5;
   localparam logic [63:0] E1 = 64'h5A5A5A5A5A5A5A5A;
   localparam logic [63:0] MIX = 64'h5A5A5A5A76543210;

   sdm_ctl_model ctl_u (.clk_in(clk), .nrst_in(nrst), .sel_n_out(sel_n),
      .rcw_out(rcw), .cke_out(cke), .ba_out(ba), .a_out(a),
      .mask_out(mask), .dq_out(dqc), .ready_out(ready));
   sdm_cmd_if dut_u (.CLK_IN(clk), .NRST_IN(nrst),
      .RANK_SELECT_N_IN(sel_n), .ROW_STROBE_N_IN(rcw[2]),
      .COL_STROBE_N_IN(rcw[1]), .WRITE_ENABLE_N_IN(rcw[0]),
      .CLOCK_ENABLE_LINES_IN(cke), .BANK_ADDRESS_BITS_IN(ba),
      .MULTIPLEXED_ADDRESS_IN(a), .BYTE_LANE_MASK_IN(mask),
      .DATA_BUS_LINES_IN(dq_wire), .DATA_BUS_LINES_OUT(dout),
      .DATA_BUS_LINES_OE_OUT(doe), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
      .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack));

   // wire level per byte lane from the device's lane enables; the controller drives every lane the device leaves off
   always_comb begin
      for (int i = 0; i < LANES; i++) begin
         dq_wire[8*i +: 8] = doe[i] ? dout[8*i +: 8] : dqc[8*i +: 8];
      end
   end

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [63:0] seen,
      input logic [63:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask

   // classic single cycle; held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] ad,
      input logic [31:0] d);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= d;
      sel <= 4'hF;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      r = rdat;
      if (n >= 50) mismatches++;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic cmd(input logic [1:0] k, input logic [2:0] c,
      input logic [1:0] b, input logic [12:0] ad);
      ctl_u.op(4'hE, k, c, b, ad, 0, 0, 0, 0);
   endtask

   // two read beats then bus release, looked at mid-cycle
   task automatic beats(input logic [7:0] oe0, input logic [63:0] e0,
      input logic [63:0] e1);
      @(negedge clk);
      chk("oe0", doe, oe0);
      chk("beat0", dout[55:0], e0[55:0]);
      @(negedge clk);
      chk("oe1", doe, 8'hFF);
      chk("beat1", dout, e1);
      @(negedge clk);
      chk("oe_end", doe, 8'h00);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // watchdog: init wait plus 7500 cycles, well above the 120 or so the tests take
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      test_done;
   end

   initial begin
      {nrst, cyc, stb, we, adr, wdat} = '0;
      sel = 4'hF;
      mismatches = 0;
      checks_done = 0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      while (ready !== 1'b1) @(posedge clk);
      wb(1'b0, REG_STATUS, 0);
      chk("mode", r[11:0], 12'h021);
      chk("state", r[17:12], 6'h01);
      wb(1'b0, 8'hFC, 0);
      chk("unmapped", r, 0);
      wb(1'b1, REG_CTRL, 32'h5);
      wb(1'b0, REG_CTRL, 0);
      chk("ctrl", r, 32'h5);
      wb(1'b1, REG_CTRL, 32'h0);
      cmd(2'h3, ctl_u.C_ACT, 2'h1, 13'h0003);
      wb(1'b0, REG_STATUS, 0);
      chk("open1", r[23:20], 4'h2);
      ctl_u.op(4'hE, 2'h3, ctl_u.C_WR, 2'h1, 13'h0004, D0, D1, 0, 0);
      ctl_u.op(4'hE, 2'h3, ctl_u.C_WR, 2'h1, 13'h0004, E0, E1, 0, 8'h0F);
      ctl_u.op(4'hF, 2'h3, ctl_u.C_WR, 2'h1, 13'h0004, 0, 0, 0, 0);
      ctl_u.op(4'hE, 2'h3, ctl_u.C_RD, 2'h1, 13'h0005, 0, 0, 8'h80, 0);
      beats(8'h7F, MIX, E0);
      cmd(2'h3, ctl_u.C_RD, 2'h1, 13'h0404);
      beats(8'hFF, E0, MIX);
      wb(1'b0, REG_STATUS, 0);
      chk("autopre", r[23:20], 4'h0);
      cmd(2'h3, ctl_u.C_ACT, 2'h0, 13'h0000);
      cmd(2'h3, ctl_u.C_ACT, 2'h2, 13'h0001);
      cmd(2'h3, ctl_u.C_PRE, 2'h2, 13'h0000);
      wb(1'b0, REG_STATUS, 0);
      chk("pre_one", r[23:20], 4'h1);
      cmd(2'h3, ctl_u.C_PRE, 2'h2, 13'h0400);
      wb(1'b0, REG_STATUS, 0);
      chk("pre_all", r[23:20], 4'h0);
      wb(1'b1, REG_CTRL, 32'h1);
      cmd(2'h3, ctl_u.C_ACT, 2'h3, 13'h0000);
      wb(1'b0, REG_STATUS, 0);
      chk("rank_off", r[23:20], 4'h0);
      wb(1'b1, REG_CTRL, 32'h0);
      cmd(2'h0, ctl_u.C_NOP, 2'h0, 13'h0000);
      cmd(2'h0, ctl_u.C_ACT, 2'h3, 13'h0000);
      wb(1'b0, REG_STATUS, 0);
      chk("pwrdn", r[17:12], 6'h08);
      cmd(2'h3, ctl_u.C_NOP, 2'h0, 13'h0000);
      wb(1'b0, REG_STATUS, 0);
      chk("ignored", r[23:12], 12'h001);
      cmd(2'h0, ctl_u.C_REF, 2'h0, 13'h0000);
      wb(1'b0, REG_STATUS, 0);
      chk("selfref", r[17:12], 6'h10);
      cmd(2'h3, ctl_u.C_NOP, 2'h0, 13'h0000);
      wb(1'b0, REG_STATUS, 0);
      chk("wake", r[17:12], 6'h01);
      wb(1'b0, REG_REFCNT, 0);
      chk("refcnt", r, 32'h3);
      // latency three: same burst, data one edge later
      cmd(2'h3, ctl_u.C_MRS, 2'h0, 13'h0031);
      cmd(2'h3, ctl_u.C_ACT, 2'h1, 13'h0003);
      cmd(2'h3, ctl_u.C_RD, 2'h1, 13'h0005);
      @(posedge clk);
      beats(8'hFF, MIX, E0);
      test_done;
   end
endmodule
